// file: common/cpw_pkg.sv
package cpw_pkg;

   // ****************************************
   // register map (word offsets, byte address)
   // ****************************************
   localparam logic [7:0] CTRL_OFS    = 8'h00;  // control_register_zero
   localparam logic [7:0] MODE_OFS    = 8'h04;  // mode_select_field
   localparam logic [7:0] OPT_OFS     = 8'h08;  // option_register
   localparam logic [7:0] EDGE_OFS    = 8'h0C;  // capture_edge_control
   localparam logic [7:0] OCTL_OFS    = 8'h10;  // output_control_reg
   localparam logic [7:0] EVT_OFS     = 8'h14;  // event_input_control
   localparam logic [7:0] CNT_OFS     = 8'h18;  // counter_read_buffer
   localparam logic [7:0] CCR0_OFS    = 8'h1C;  // capture_compare_reg 0
   localparam logic [7:0] CCR1_OFS    = 8'h20;  // capture_compare_reg 1
   localparam logic [7:0] IRQ_ST_OFS  = 8'h24;
   localparam logic [7:0] IRQ_MSK_OFS = 8'h28;
   localparam logic [7:0] PRESC_OFS   = 8'h2C;

   // ****************************************
   // field positions and values
   // ****************************************
   localparam int          RUN_BIT     = 0;
   localparam int          OVF_BIT     = 0;
   localparam int          CCS0_BIT    = 4;
   localparam int          CCS1_BIT    = 5;
   localparam logic [2:0]  MODE_FREE   = 3'h5;
   localparam logic [2:0]  MODE_PWM    = 3'h6;
   localparam logic [15:0] CNT_MAX     = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO    = 16'h0000;
   localparam logic [15:0] CNT_IDLE    = 16'hFFFF;
   localparam logic [7:0]  BYTE_RST    = 8'h00;
   localparam logic [15:0] PRESC_RST   = 16'h0000;
   localparam int          IRQ_CC0     = 0;
   localparam int          IRQ_CC1     = 1;
   localparam int          IRQ_OVF     = 2;

   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_sel_t;

   // bus request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

endpackage

// file: core/edge_detect.sv
`timescale 1ns/1ps
module edge_detect (
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // pin and selection
   input  wire logic                pin_i,
   input  wire cpw_pkg::edge_sel_t  sel_i,
   // qualified edge
   output logic                     edge_o
);
   import cpw_pkg::*;

   logic       sync1_reg;
   logic       sync2_reg;
   logic       sync3_reg;
   logic       level_reg;
   logic       rise;
   logic       fall;

   // three stages; first stage read only by the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_i;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // accepted level changes only when stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_reg <= 1'b0;
      end else if (sync2_reg == sync3_reg) begin
         level_reg <= sync3_reg;
      end
   end

   assign rise = (sync2_reg == sync3_reg) && sync3_reg && !level_reg;
   assign fall = (sync2_reg == sync3_reg) && !sync3_reg && level_reg;

   // edge qualification
   always_comb begin
      case (sel_i)
         EDGE_NONE: edge_o = 1'b0;
         EDGE_RISE: edge_o = rise;
         EDGE_FALL: edge_o = fall;
         EDGE_BOTH: edge_o = rise | fall;
         default:   edge_o = 1'b0;
      endcase
   end

endmodule // edge_detect

// file: core/count_tick.sv
`timescale 1ns/1ps
module count_tick (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // control
   input  wire logic        run_i,
   input  wire logic [15:0] div_i,
   // one-cycle count clock pulse
   output logic             tick_o
);
   import cpw_pkg::*;

   logic [15:0] div_reg;

   // divide peripheral clock by div_i+1; restarts while stopped
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         div_reg <= PRESC_RST;
      end else if (div_reg >= div_i) begin
         div_reg <= PRESC_RST;
      end else begin
         div_reg <= div_reg + 16'h0001;
      end
   end

   assign tick_o = run_i && (div_reg >= div_i);

endmodule // count_tick

// file: core/capture_pulse_width_timer.sv
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Function
// - mode 110 selects pulse-width measurement
// - run_enable starts counter on count clock
// - pulse mode: edge captures count, clears counter, interrupts
// - after FFFFH: overflow irq, wrap, flag
// - overflow flag cleared by writing zero, only after a read has seen it set
// - early capture may latch FFFFH
// - pulse mode: capture only, controls ignored
// - counter read buffer returns counter, zero when stopped
// - mode 101 free-running, wraps at max
// - select bit chooses capture or compare
// - compare match fires at D plus one
module capture_pulse_width_timer (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // wishbone slave
   input  wire cpw_pkg::wb_req_t   wb_i,
   output logic [31:0]             wb_dat_o,
   output logic                    wb_ack_o,
   // capture trigger inputs
   input  wire logic [1:0]         capture_trigger_input_i,
   // interrupts
   output logic                    capture_match_irq_o,
   output logic                    overflow_irq_o,
   output logic                    irq_o
);
   import cpw_pkg::*;

   // ****************************************
   // registers
   // ****************************************
   logic        run_enable_reg;
   logic [2:0]  mode_select_field_reg;
   logic [7:0]  option_register_reg;
   logic [3:0]  capture_edge_control_reg;
   logic [7:0]  output_control_reg;
   logic [7:0]  event_input_control_reg;
   logic [15:0] presc_reg;
   logic [15:0] counter_reg;
   logic [15:0] ccr_reg [2];
   logic [2:0]  irq_st_reg;
   logic [2:0]  irq_msk_reg;
   logic        ack_reg;
   logic [31:0] rdat_reg;
   logic        ovf_seen_reg;
   logic [1:0]  cmp_hit_reg;
   logic        started_reg;

   logic        tick;
   logic [1:0]  edge_hit;
   logic        pwm_mode;
   logic        free_mode;
   logic        wr;
   logic        rd;
   logic        wrap;
   logic [1:0]  cap_ev;
   logic [1:0]  cmp_ev;
   logic [2:0]  ev;

   function automatic logic [15:0] lo16(input logic [31:0] d, input logic [3:0] s, input logic [15:0] old);
      lo16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   assign pwm_mode  = (mode_select_field_reg == MODE_PWM);
   assign free_mode = (mode_select_field_reg == MODE_FREE);
   assign wr = wb_i.cyc && wb_i.stb && wb_i.we && !ack_reg;
   assign rd = wb_i.cyc && wb_i.stb && !wb_i.we && !ack_reg;

   // ****************************************
   // count clock and edge detectors
   // ****************************************
   count_tick u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (run_enable_reg),
      .div_i  (presc_reg),
      .tick_o (tick)
   );

   for (genvar g = 0; g < 2; g++) begin : g_edge
      edge_detect u_edge (
         .clk_i  (clk_i),
         .rst_i  (rst_i),
         .pin_i  (capture_trigger_input_i[g]),
         .sel_i  (edge_sel_t'(capture_edge_control_reg[2*g +: 2])),
         .edge_o (edge_hit[g])
      );
   end

   // capture per register: always in pulse mode, by select bit in free mode
   assign cap_ev[0] = run_enable_reg && edge_hit[0] &&
                      (pwm_mode || (free_mode && option_register_reg[CCS0_BIT]));
   assign cap_ev[1] = run_enable_reg && edge_hit[1] &&
                      (pwm_mode || (free_mode && option_register_reg[CCS1_BIT]));
   // no overflow on the first tick after enable (counter only leaves idle), nor when an edge clears it
   assign wrap = run_enable_reg && tick && started_reg && (counter_reg == CNT_MAX) &&
                 !(pwm_mode && (cap_ev != 2'b00));
   assign ev = {wrap, cap_ev | cmp_ev};

   // ****************************************
   // counter
   // ****************************************
   // idle value FFFFH means a trigger right after enable may capture FFFFH
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_enable_reg) begin
         counter_reg <= CNT_IDLE;
      end else if (pwm_mode && (cap_ev != 2'b00)) begin
         counter_reg <= CNT_ZERO;
      end else if (tick) begin
         counter_reg <= counter_reg + 16'h0001;
      end
   end

   // marks the first count-clock tick since enable
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_enable_reg) begin
         started_reg <= 1'b0;
      end else if (tick) begin
         started_reg <= 1'b1;
      end
   end

   // compare match: counter steps from D to D+1
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_hit_reg <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            cmp_hit_reg[i] <= run_enable_reg && tick && free_mode &&
                              !option_register_reg[CCS0_BIT + i] && (counter_reg == ccr_reg[i]);
         end
      end
   end
   assign cmp_ev = cmp_hit_reg;

   // ****************************************
   // capture/compare registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ccr_reg[0] <= CNT_ZERO;
         ccr_reg[1] <= CNT_ZERO;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (cap_ev[i]) begin
               ccr_reg[i] <= counter_reg;
            end else if (wr && !pwm_mode && wb_i.adr == (CCR0_OFS + 8'(4 * i))) begin
               ccr_reg[i] <= lo16(wb_i.dat, wb_i.sel, ccr_reg[i]);
            end
         end
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_enable_reg           <= 1'b0;
         mode_select_field_reg    <= 3'h0;
         capture_edge_control_reg <= 4'h0;
         output_control_reg       <= BYTE_RST;
         event_input_control_reg  <= BYTE_RST;
         presc_reg                <= PRESC_RST;
         irq_msk_reg              <= 3'h0;
      end else if (wr && wb_i.sel[0]) begin
         case (wb_i.adr)
            CTRL_OFS:    run_enable_reg           <= wb_i.dat[RUN_BIT];
            MODE_OFS:    mode_select_field_reg    <= wb_i.dat[2:0];
            EDGE_OFS:    capture_edge_control_reg <= wb_i.dat[3:0];
            OCTL_OFS:    output_control_reg       <= wb_i.dat[7:0];
            EVT_OFS:     event_input_control_reg  <= wb_i.dat[7:0];
            PRESC_OFS:   presc_reg                <= lo16(wb_i.dat, wb_i.sel, presc_reg);
            IRQ_MSK_OFS: irq_msk_reg              <= wb_i.dat[2:0];
            default:     ;
         endcase
      end
   end

   // option register in one process; overflow set wins over a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         option_register_reg <= BYTE_RST;
         ovf_seen_reg        <= 1'b0;
      end else begin
         if (wr && wb_i.sel[0] && wb_i.adr == OPT_OFS) begin
            option_register_reg[7:1] <= wb_i.dat[7:1];
         end
         if (!run_enable_reg) begin
            option_register_reg[OVF_BIT] <= 1'b0;
            ovf_seen_reg                 <= 1'b0;
         end else if (wrap) begin
            option_register_reg[OVF_BIT] <= 1'b1;
         end else if (wr && wb_i.sel[0] && wb_i.adr == OPT_OFS && !wb_i.dat[OVF_BIT] && ovf_seen_reg) begin
            option_register_reg[OVF_BIT] <= 1'b0;
            ovf_seen_reg                 <= 1'b0;
         end else if (rd && wb_i.adr == OPT_OFS && option_register_reg[OVF_BIT]) begin
            ovf_seen_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // interrupts: sticky, write one to clear, set wins
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_reg <= 3'h0;
      end else begin
         irq_st_reg <= ev | (irq_st_reg &
                       ~((wr && wb_i.sel[0] && wb_i.adr == IRQ_ST_OFS) ? wb_i.dat[2:0] : 3'h0));
      end
   end

   assign capture_match_irq_o = (ev[IRQ_CC0] | ev[IRQ_CC1]);
   assign overflow_irq_o      = ev[IRQ_OVF];
   assign irq_o               = |(irq_st_reg & irq_msk_reg);

   // ****************************************
   // bus read and ack, one cycle after the request
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= wb_i.cyc && wb_i.stb && !ack_reg;
         if (rd) begin
            case (wb_i.adr)
               CTRL_OFS:    rdat_reg <= {31'h0, run_enable_reg};
               MODE_OFS:    rdat_reg <= {29'h0, mode_select_field_reg};
               OPT_OFS:     rdat_reg <= {24'h0, option_register_reg};
               EDGE_OFS:    rdat_reg <= {28'h0, capture_edge_control_reg};
               OCTL_OFS:    rdat_reg <= {24'h0, output_control_reg};
               EVT_OFS:     rdat_reg <= {24'h0, event_input_control_reg};
               CNT_OFS:     rdat_reg <= {16'h0, run_enable_reg ? counter_reg : CNT_ZERO};
               CCR0_OFS:    rdat_reg <= {16'h0, ccr_reg[0]};
               CCR1_OFS:    rdat_reg <= {16'h0, ccr_reg[1]};
               IRQ_ST_OFS:  rdat_reg <= {29'h0, irq_st_reg};
               IRQ_MSK_OFS: rdat_reg <= {29'h0, irq_msk_reg};
               PRESC_OFS:   rdat_reg <= {16'h0, presc_reg};
               default:     rdat_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   // ****************************************
   // assertions
   // ****************************************
   sequence s_pwm_edge;
      run_enable_reg && pwm_mode && cap_ev[0];
   endsequence

   property p_mode_pwm;
      @(posedge clk_i) disable iff (rst_i)
         (run_enable_reg && mode_select_field_reg == 3'h6 && edge_hit[0]) |=> counter_reg == 16'h0000 && irq_st_reg[0];
   endproperty
   a_mode_pwm: assert property (p_mode_pwm) else $error("pulse mode not decoded");

   property p_count_up;
      @(posedge clk_i) disable iff (rst_i)
         (run_enable_reg && tick && !wrap && cap_ev == 2'b00 && $past(run_enable_reg))
         |=> counter_reg == $past(counter_reg) + 16'h0001;
   endproperty
   a_count_up: assert property (p_count_up) else $error("counter did not advance");

   property p_capture_clear;
      @(posedge clk_i) disable iff (rst_i)
         s_pwm_edge |=> (ccr_reg[0] == $past(counter_reg)) && (counter_reg == 16'h0000) && irq_st_reg[0];
   endproperty
   a_capture_clear: assert property (p_capture_clear) else $error("capture did not latch and clear");

   property p_wrap;
      @(posedge clk_i) disable iff (rst_i)
         (wrap && cap_ev == 2'b00) |-> overflow_irq_o ##1 (counter_reg == 16'h0000 && option_register_reg[0]);
   endproperty
   a_wrap: assert property (p_wrap) else $error("overflow not handled");

   property p_ovf_hold;
      @(posedge clk_i) disable iff (rst_i)
         (option_register_reg[0] && run_enable_reg && !ovf_seen_reg) |=> option_register_reg[0] || !run_enable_reg;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag cleared unread");

   property p_no_cap_free_cmp;
      @(posedge clk_i) disable iff (rst_i)
         (free_mode && !option_register_reg[CCS0_BIT]) |-> !cap_ev[0];
   endproperty
   a_no_cap_free_cmp: assert property (p_no_cap_free_cmp) else $error("compare register captured");

   property p_cmp_match;
      @(posedge clk_i) disable iff (rst_i)
         (run_enable_reg && tick && free_mode && !option_register_reg[CCS1_BIT] && counter_reg == ccr_reg[1])
         |=> cmp_ev[1] && (counter_reg == $past(counter_reg) + 16'h0001);
   endproperty
   a_cmp_match: assert property (p_cmp_match) else $error("compare match missed");

   property p_cnt_read;
      @(posedge clk_i) disable iff (rst_i)
         (rd && wb_i.adr == CNT_OFS && run_enable_reg) |=> wb_ack_o && wb_dat_o[15:0] == $past(counter_reg);
   endproperty
   a_cnt_read: assert property (p_cnt_read) else $error("counter read mismatch");

   property p_no_start_ovf;
      @(posedge clk_i) disable iff (rst_i)
         (tick && !started_reg) |-> !overflow_irq_o;
   endproperty
   a_no_start_ovf: assert property (p_no_start_ovf) else $error("overflow on first count after enable");

endmodule // capture_pulse_width_timer

// file: tb/cpw_pulse_source.sv
`timescale 1ns/1ps
// ****************************************
// far-side pulse source on the capture pins
// ****************************************
module cpw_pulse_source (
   // clock
   input  wire logic  clk_i,
   // capture pins
   output logic [1:0] pin_o
);
   // pins idle low; no pull-up on these lines
   initial pin_o = 2'b00;

   // one edge, changed just after a clock edge
   task automatic drive(input int ch, input logic v);
      @(posedge clk_i);
      pin_o[ch] <= v;
   endtask

   // a high pulse of hi cycles on one pin only
   task automatic pulse(input int ch, input int hi);
      drive(ch, 1'b1);
      repeat (hi) @(posedge clk_i);
      pin_o[ch] <= 1'b0;
   endtask

   // two rising edges exactly gap cycles apart, so the width is exact
   task automatic rise_pair(input int ch, input int gap);
      drive(ch, 1'b1);
      repeat (gap / 2) @(posedge clk_i);
      pin_o[ch] <= 1'b0;
      repeat (gap - gap / 2) @(posedge clk_i);
      pin_o[ch] <= 1'b1;
      repeat (8) @(posedge clk_i);
      pin_o[ch] <= 1'b0;
   endtask
endmodule // cpw_pulse_source

// file: tb/capture_pulse_width_timer_test.sv
`timescale 1ns/1ps
module capture_pulse_width_timer_test;
   import cpw_pkg::*;
   logic        clk_i;
   logic        rst_i;
   wb_req_t     req;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [1:0]  pins;
   logic        capture_match_irq_o;
   logic        overflow_irq_o;
   logic        irq_o;
   int          err_total;
   int          n_compared;
   int          cap_cnt;
   int          ovf_cnt;
   int          n0;
   logic [31:0] v;
   logic [31:0] c;
   logic [31:0] a1;

   capture_pulse_width_timer i_capture_pulse_width_timer (
      .clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .capture_trigger_input_i(pins), .capture_match_irq_o(capture_match_irq_o),
      .overflow_irq_o(overflow_irq_o), .irq_o(irq_o));
   cpw_pulse_source i_cpw_pulse_source (.clk_i(clk_i), .pin_o(pins));

   // ****************************************
   // clock, event counters, watchdog
   // ****************************************
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // count irq pulses; they stand one cycle only
   always @(posedge clk_i) begin
      if (capture_match_irq_o === 1'b1) cap_cnt++;
      if (overflow_irq_o === 1'b1) ovf_cnt++;
   end
   // the overflow wait dominates, about 66k cycles
   initial begin
      repeat (90000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic cycle; ack sampled at the edge, released after it
   task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      // waits as long as it takes; only the watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb_cycle(1'b0, a, 32'h0, q);
   endtask
   // restart the run, then capture one gap between two rising edges
   task automatic measure(input int gap, output logic [31:0] q);
      wr(CTRL_OFS, 32'h0);
      wr(CTRL_OFS, 32'h1);
      i_cpw_pulse_source.rise_pair(0, gap);
      repeat (20) @(posedge clk_i);
      rd(CCR0_OFS, q);
   endtask
   task automatic print_verdict();
      if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      err_total = 0;
      n_compared = 0;
      cap_cnt = 0;
      ovf_cnt = 0;
      req = '0;
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(MODE_OFS, v); check("mode reset", v, 32'h0);
      rd(OPT_OFS, v); check("opt reset", v, 32'h0);
      rd(CNT_OFS, v); check("count stopped", v, 32'h0);
      wr(8'h40, 32'hFF);
      rd(8'h40, v); check("unmapped", v, 32'h0);
      // slow count clock: a trigger right after enable sees the idle value
      wr(PRESC_OFS, 32'h0FFF);
      wr(MODE_OFS, {29'h0, MODE_PWM});
      wr(EDGE_OFS, 32'h1);
      wr(CTRL_OFS, 32'h1);
      i_cpw_pulse_source.pulse(0, 4);
      repeat (20) @(posedge clk_i);
      rd(CCR0_OFS, v); check("early capture", v, 32'hFFFF);
      // every edge selection against one rise and one fall
      wr(PRESC_OFS, 32'h0);
      for (int e = 0; e < 4; e++) begin
         wr(CTRL_OFS, 32'h0);
         wr(EDGE_OFS, e);
         wr(CTRL_OFS, 32'h1);
         n0 = cap_cnt;
         i_cpw_pulse_source.pulse(0, 20);
         repeat (20) @(posedge clk_i);
         check("edge captures", 32'(cap_cnt - n0), (e == 0) ? 0 : (e == 3) ? 2 : 1);
      end
      // widths: two gaps at half rate differ by exactly 60 counts
      wr(PRESC_OFS, 32'h1);
      wr(EDGE_OFS, 32'h1);
      wr(OCTL_OFS, 32'hFF);
      wr(EVT_OFS, 32'hFF);
      measure(80, a1);
      measure(200, v);
      check("width diff", v - a1, 32'd60);
      rd(CNT_OFS, c); check("cleared on capture", {31'h0, c < 32}, 32'h1);
      wr(CCR0_OFS, 32'h1234);
      rd(CCR0_OFS, c); check("capture only", c, v);
      rd(IRQ_ST_OFS, c); check("capture status", {31'h0, c[IRQ_CC0]}, 32'h1);
      wr(IRQ_MSK_OFS, 32'h0); check("masked", {31'h0, irq_o}, 32'h0);
      wr(IRQ_MSK_OFS, 32'h1); check("unmasked", {31'h0, irq_o}, 32'h1);
      wr(IRQ_ST_OFS, 32'h1); check("w1c", {31'h0, irq_o}, 32'h0);
      // overflow with no edge at all
      wr(CTRL_OFS, 32'h0);
      wr(EDGE_OFS, 32'h0);
      wr(PRESC_OFS, 32'h0);
      wr(IRQ_MSK_OFS, 32'h4);
      n0 = ovf_cnt;
      wr(CTRL_OFS, 32'h1);
      repeat (100) @(posedge clk_i);
      check("no overflow at start", 32'(ovf_cnt - n0), 32'h0);
      repeat (70000) if (ovf_cnt == n0) @(posedge clk_i);
      check("overflow pulses", 32'(ovf_cnt - n0), 32'h1);
      rd(CNT_OFS, c); check("wrapped", {31'h0, c < 64}, 32'h1);
      check("overflow irq", {31'h0, irq_o}, 32'h1);
      wr(OPT_OFS, 32'h0);
      rd(OPT_OFS, c); check("flag needs read first", {31'h0, c[OVF_BIT]}, 32'h1);
      wr(OPT_OFS, 32'h0);
      rd(OPT_OFS, c); check("flag cleared", {31'h0, c[OVF_BIT]}, 32'h0);
      // free-running: register 0 compares, register 1 captures
      wr(CTRL_OFS, 32'h0);
      wr(IRQ_ST_OFS, 32'h7);
      wr(MODE_OFS, {29'h0, MODE_FREE});
      wr(OPT_OFS, 32'h20);
      wr(CCR0_OFS, 32'd200);
      wr(EDGE_OFS, 32'h4);
      n0 = cap_cnt;
      wr(CTRL_OFS, 32'h1);
      repeat (400) if (cap_cnt == n0) @(posedge clk_i);
      rd(CNT_OFS, c); check("match at D plus one", {31'h0, (c - 32'd201) < 12}, 32'h1);
      wr(CCR0_OFS, 32'd400);
      n0 = cap_cnt;
      repeat (400) if (cap_cnt == n0) @(posedge clk_i);
      rd(CNT_OFS, c); check("reloaded match", {31'h0, (c - 32'd401) < 12}, 32'h1);
      i_cpw_pulse_source.pulse(1, 4);
      repeat (20) @(posedge clk_i);
      rd(CCR1_OFS, v);
      rd(CNT_OFS, c); check("free capture keeps count", {31'h0, c > v && v > 32'd401}, 32'h1);
      rd(CCR0_OFS, c); check("compare untouched", c, 32'd400);
      print_verdict();
   end
endmodule // capture_pulse_width_timer_test
